/* File: shared/sbm_pkg.sv */
// Shared constants, enumerations and carriers for the serial-bus byte master
`default_nettype none

package sbm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and reset value
  // ----------------------------------------------------------------------
  localparam logic [7:0] SBM_OFS_TRANSFER_BYTE = 8'hb0;
  localparam logic [7:0] SBM_OFS_BYTE_ADDRESS = 8'hb1;
  localparam logic [7:0] SBM_OFS_TARGET_ADDRESS = 8'hb2;
  localparam logic [7:0] SBM_OFS_CONTROL_STATUS = 8'hb3;
  localparam logic [7:0] SBM_RESET_BYTE = 8'h00;

  // ----------------------------------------------------------------------
  // Control and status bit positions
  // ----------------------------------------------------------------------
  localparam int SBM_BIT_SHORT = 7;
  localparam int SBM_BIT_RSVD = 6;
  localparam int SBM_BIT_BUSY = 5;
  localparam int SBM_BIT_LOAD = 4;
  localparam int SBM_BIT_PRESENT = 3;
  localparam int SBM_BIT_FAST = 2;
  localparam int SBM_BIT_REQ_ERR = 1;
  localparam int SBM_BIT_ROM_ERR = 0;

  // ----------------------------------------------------------------------
  // Timing and load constants
  // ----------------------------------------------------------------------
  localparam int SBM_SCL_PERIOD_NS = 10000;
  localparam int SBM_FAST_RATIO = 8;
  localparam logic [3:0] SBM_DETECT_QUARTERS = 4'hf;
  localparam logic [1:0] SBM_LOAD_LAST = 2'h2;
  localparam logic [3:0] SBM_LAST_BIT = 4'h8;

  // ----------------------------------------------------------------------
  // Link engine states (Gray along idle-start-bits-stop) and byte segments
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SBM_L_DETECT = 3'h0,
    SBM_L_IDLE = 3'h1,
    SBM_L_START = 3'h3,
    SBM_L_BITS = 3'h2,
    SBM_L_STOP = 3'h6
  } sbm_link_st_e;

  typedef enum logic [2:0] {
    SBM_SG_ADDR_W = 3'h0,
    SBM_SG_INDEX = 3'h1,
    SBM_SG_ADDR_R = 3'h3,
    SBM_SG_WDATA = 3'h2,
    SBM_SG_RDATA = 3'h6
  } sbm_seg_e;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbm_cfg_req_s;

  typedef struct packed {
    logic [6:0] target_address_field;
    logic direction_bit;
    logic [7:0] byte_address_field;
    logic [7:0] transfer_byte;
    logic short_protocol_select;
  } sbm_req_s;

  typedef struct packed {
    logic [7:0] transfer_byte;
    logic err;
  } sbm_res_s;

  typedef struct packed {
    logic serial_clock_pin_o;
    logic serial_clock_pin_oe_n;
    logic serial_data_pin_o;
    logic serial_data_pin_oe_n;
  } sbm_pins_s;

endpackage : sbm_pkg

`default_nettype wire

/* File: rtl/sbm_serial_bus_byte_master.sv */
// Two-wire serial-bus byte master with EEPROM auto-load and config registers
`default_nettype none

module sbm_serial_bus_byte_master
  import sbm_pkg::*;
#(
  parameter int LINK_CLK_NS = 48,
  parameter logic [6:0] EEPROM_TARGET = 7'h50,
  parameter logic [7:0] EEPROM_HEADER = 8'ha5
) (
  // Clocks and reset
  input wire logic ref_clk_in,
  input wire logic link_clk_in,
  input wire logic arst_n_in,
  // Configuration register port
  input wire sbm_cfg_req_s cfg_req_in,
  output logic [7:0] cfg_rdata_out,
  // Serial pins
  input wire logic serial_clock_pin_in,
  input wire logic serial_data_pin_in,
  output sbm_pins_s pins_out,
  // Status towards the rest of the chip
  output logic bus_present_flag_out,
  output logic eeprom_load_active_out,
  output logic [15:0] subsystem_id_out
);

  // ----------------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------------
  localparam int QTR_CYCLES = SBM_SCL_PERIOD_NS / (4 * LINK_CLK_NS);
  localparam logic [15:0] QTR_NORM = 16'(QTR_CYCLES - 1);
  localparam logic [15:0] QTR_FAST = 16'(QTR_CYCLES / SBM_FAST_RATIO - 1);

  // ----------------------------------------------------------------------
  // State structures
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] transfer_byte;
    logic [7:0] byte_address_field;
    logic [7:0] target;
    logic short_protocol_select;
    logic fast_clock_test;
    logic req_err;
    logic rom_err;
    logic request_in_progress;
    logic req_tgl;
    logic done_s1, done_s2, done_seen;
    logic load_s1, load_s2, load_prev;
    logic pres_s1, pres_s2;
    logic romerr_s1, romerr_s2, romerr_seen;
    sbm_req_s req;
    logic [7:0] rdata;
    logic [15:0] sub_id;
  } sbm_ref_s;

  typedef struct packed {
    sbm_link_st_e st;
    sbm_seg_e seg;
    logic [1:0] q;
    logic [15:0] qcnt;
    logic [3:0] bcnt;
    logic [7:0] tx;
    logic [8:0] rx;
    logic scl_s1, scl_s2, sda_s1, sda_s2;
    logic req_s1, req_s2, req_seen;
    logic fast_s1, fast_s2;
    sbm_req_s job;
    logic auto_job;
    logic eeprom_load_active;
    logic bus_present_flag;
    logic [1:0] idx;
    logic [15:0] sub_id;
    logic err;
    logic done_tgl;
    logic romerr_tgl;
    sbm_res_s res;
    logic scl_oe_n, sda_oe_n;
  } sbm_link_s;

  localparam sbm_ref_s REF_RST = '{load_s1: 1'b1, load_s2: 1'b1, load_prev: 1'b1,
                                   default: '0};
  localparam sbm_link_s LINK_RST = '{st: SBM_L_DETECT, seg: SBM_SG_ADDR_W,
                                     eeprom_load_active: 1'b1, scl_oe_n: 1'b1,
                                     sda_oe_n: 1'b1, job: '0, res: '0, default: '0};

  sbm_ref_s rs, next_rs;
  sbm_link_s ls, next_ls;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Register hit decode
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = strobe && (addr == ofs);
  endfunction : hit

  // Byte shifted out for each segment; reads release the line
  function automatic logic [7:0] tx_byte(input sbm_seg_e seg, input sbm_req_s job);
    case (seg)
      SBM_SG_ADDR_W: tx_byte = {job.target_address_field, 1'b0};
      SBM_SG_ADDR_R: tx_byte = {job.target_address_field, 1'b1};
      SBM_SG_INDEX: tx_byte = job.byte_address_field;
      SBM_SG_WDATA: tx_byte = job.transfer_byte;
      default: tx_byte = 8'hff;
    endcase
  endfunction : tx_byte

  // Control and status byte as software sees it
  function automatic logic [7:0] status_byte(input sbm_ref_s r);
    status_byte = SBM_RESET_BYTE;
    status_byte[SBM_BIT_SHORT] = r.short_protocol_select;
    status_byte[SBM_BIT_RSVD] = 1'b0;
    status_byte[SBM_BIT_BUSY] = r.request_in_progress;
    status_byte[SBM_BIT_LOAD] = r.load_s2;
    status_byte[SBM_BIT_PRESENT] = r.pres_s2;
    status_byte[SBM_BIT_FAST] = r.fast_clock_test;
    status_byte[SBM_BIT_REQ_ERR] = r.req_err;
    status_byte[SBM_BIT_ROM_ERR] = r.rom_err;
  endfunction : status_byte

  // ----------------------------------------------------------------------
  // Host-clock domain: registers, request launch, result capture
  // ----------------------------------------------------------------------
  logic wr_target, done_evt, romerr_evt;
  assign wr_target = hit(cfg_req_in.wr, cfg_req_in.addr, SBM_OFS_TARGET_ADDRESS);
  assign done_evt = rs.done_s2 != rs.done_seen;
  assign romerr_evt = rs.romerr_s2 != rs.romerr_seen;

  // Next state of the host-side registers
  always_comb begin
    next_rs = rs;
    next_rs.done_s1 = ls.done_tgl;
    next_rs.done_s2 = rs.done_s1;
    next_rs.done_seen = rs.done_s2;
    next_rs.load_s1 = ls.eeprom_load_active;
    next_rs.load_s2 = rs.load_s1;
    next_rs.load_prev = rs.load_s2;
    next_rs.pres_s1 = ls.bus_present_flag;
    next_rs.pres_s2 = rs.pres_s1;
    next_rs.romerr_s1 = ls.romerr_tgl;
    next_rs.romerr_s2 = rs.romerr_s1;
    next_rs.romerr_seen = rs.romerr_s2;
    if (hit(cfg_req_in.wr, cfg_req_in.addr, SBM_OFS_TRANSFER_BYTE)) begin
      next_rs.transfer_byte = cfg_req_in.wdata;
    end
    if (hit(cfg_req_in.wr, cfg_req_in.addr, SBM_OFS_BYTE_ADDRESS)) begin
      next_rs.byte_address_field = cfg_req_in.wdata;
    end
    if (hit(cfg_req_in.wr, cfg_req_in.addr, SBM_OFS_CONTROL_STATUS)) begin
      next_rs.short_protocol_select = cfg_req_in.wdata[SBM_BIT_SHORT];
      next_rs.fast_clock_test = cfg_req_in.wdata[SBM_BIT_FAST];
      next_rs.req_err = rs.req_err & ~cfg_req_in.wdata[SBM_BIT_REQ_ERR];
      next_rs.rom_err = rs.rom_err & ~cfg_req_in.wdata[SBM_BIT_ROM_ERR];
    end
    // Completion from the link side; the error set wins over a clear
    if (done_evt) begin
      next_rs.request_in_progress = 1'b0;
      if (rs.req.direction_bit) begin
        next_rs.transfer_byte = ls.res.transfer_byte;
      end
      next_rs.req_err = next_rs.req_err | ls.res.err;
    end
    // Post a request; a write while busy only updates the register,
    // but one that meets the completion edge still posts
    if (wr_target) begin
      next_rs.target = cfg_req_in.wdata;
      if (!rs.request_in_progress || done_evt) begin
        next_rs.request_in_progress = 1'b1;
        next_rs.req_tgl = ~rs.req_tgl;
        next_rs.req = '{target_address_field: cfg_req_in.wdata[7:1],
                        direction_bit: cfg_req_in.wdata[0],
                        byte_address_field: rs.byte_address_field,
                        transfer_byte: rs.transfer_byte,
                        short_protocol_select: rs.short_protocol_select};
      end
    end
    if (romerr_evt) begin
      next_rs.rom_err = 1'b1;
    end
    // Identifier is stable once the load flag has fallen
    if (rs.load_prev && !rs.load_s2) begin
      next_rs.sub_id = ls.sub_id;
    end
    // Read data
    next_rs.rdata = rs.rdata;
    if (cfg_req_in.rd) begin
      case (cfg_req_in.addr)
        SBM_OFS_TRANSFER_BYTE: next_rs.rdata = rs.transfer_byte;
        SBM_OFS_BYTE_ADDRESS: next_rs.rdata = rs.byte_address_field;
        SBM_OFS_TARGET_ADDRESS: next_rs.rdata = rs.target;
        SBM_OFS_CONTROL_STATUS: next_rs.rdata = status_byte(rs);
        default: next_rs.rdata = SBM_RESET_BYTE;
      endcase
    end
  end

  // Host-side register bank
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rs <= REF_RST;
    end else begin
      rs <= next_rs;
    end
  end

  assign cfg_rdata_out = rs.rdata;
  assign bus_present_flag_out = rs.pres_s2;
  assign eeprom_load_active_out = rs.load_s2;
  assign subsystem_id_out = rs.sub_id;

  // ----------------------------------------------------------------------
  // Link-clock domain: bit engine, detect and EEPROM auto-load
  // ----------------------------------------------------------------------
  logic tick;
  logic [15:0] qload;
  sbm_seg_e nseg;
  assign tick = ls.qcnt == '0;
  assign qload = ls.fast_s2 ? QTR_FAST : QTR_NORM;

  // Next state of the link engine
  always_comb begin
    next_ls = ls;
    nseg = ls.seg;
    next_ls.scl_s1 = serial_clock_pin_in;
    next_ls.scl_s2 = ls.scl_s1;
    next_ls.sda_s1 = serial_data_pin_in;
    next_ls.sda_s2 = ls.sda_s1;
    next_ls.req_s1 = rs.req_tgl;
    next_ls.req_s2 = ls.req_s1;
    next_ls.fast_s1 = rs.fast_clock_test;
    next_ls.fast_s2 = ls.fast_s1;
    next_ls.qcnt = tick ? qload : ls.qcnt - 16'h0001;
    if (tick && ls.st != SBM_L_IDLE) begin
      next_ls.q = ls.q + 2'h1;
    end
    case (ls.st)
      SBM_L_DETECT: begin
        if (tick) begin
          next_ls.bcnt = ls.bcnt + 4'h1;
          next_ls.q = '0;
          if (ls.bcnt == SBM_DETECT_QUARTERS) begin
            next_ls.bus_present_flag = ls.scl_s2 && ls.sda_s2;
            if (ls.scl_s2 && ls.sda_s2) begin
              next_ls.auto_job = 1'b1;
              next_ls.idx = '0;
              next_ls.job = '{EEPROM_TARGET, 1'b1, 8'h00, 8'h00, 1'b0};
              next_ls.seg = SBM_SG_ADDR_W;
              next_ls.err = 1'b0;
              next_ls.st = SBM_L_START;
            end else begin
              next_ls.eeprom_load_active = 1'b0;
              next_ls.st = SBM_L_IDLE;
            end
          end
        end
      end
      SBM_L_IDLE: begin
        // Requests are only taken once the load is over
        if (ls.req_s2 != ls.req_seen && !ls.eeprom_load_active) begin
          next_ls.req_seen = ls.req_s2;
          next_ls.job = rs.req;
          next_ls.auto_job = 1'b0;
          next_ls.err = 1'b0;
          next_ls.q = '0;
          next_ls.qcnt = qload;
          next_ls.seg = (rs.req.short_protocol_select && rs.req.direction_bit) ?
                        SBM_SG_ADDR_R : SBM_SG_ADDR_W;
          next_ls.st = SBM_L_START;
        end
      end
      SBM_L_START: begin
        if (tick && ls.q == 2'h3) begin
          next_ls.st = SBM_L_BITS;
          next_ls.bcnt = '0;
          next_ls.tx = tx_byte(ls.seg, ls.job);
        end
      end
      SBM_L_BITS: begin
        if (tick && ls.q == 2'h1) begin
          next_ls.rx = {ls.rx[7:0], ls.sda_s2};
        end
        if (tick && ls.q == 2'h3) begin
          next_ls.tx = {ls.tx[6:0], 1'b1};
          next_ls.bcnt = ls.bcnt + 4'h1;
          if (ls.bcnt == SBM_LAST_BIT) begin
            next_ls.bcnt = '0;
            case (ls.seg)
              SBM_SG_ADDR_W: nseg = ls.job.short_protocol_select ?
                                    SBM_SG_WDATA : SBM_SG_INDEX;
              SBM_SG_INDEX: nseg = ls.job.direction_bit ?
                                   SBM_SG_ADDR_R : SBM_SG_WDATA;
              SBM_SG_ADDR_R: nseg = SBM_SG_RDATA;
              default: nseg = ls.seg;
            endcase
            next_ls.seg = nseg;
            next_ls.tx = tx_byte(nseg, ls.job);
            if (ls.seg != SBM_SG_RDATA && ls.rx[0]) begin
              next_ls.err = 1'b1;
              next_ls.st = SBM_L_STOP;
            end else if (ls.seg == SBM_SG_RDATA || ls.seg == SBM_SG_WDATA) begin
              next_ls.res.transfer_byte = ls.rx[8:1];
              next_ls.st = SBM_L_STOP;
            end else if (ls.seg == SBM_SG_INDEX && ls.job.direction_bit) begin
              next_ls.st = SBM_L_START;
            end
          end
        end
      end
      SBM_L_STOP: begin
        if (tick && ls.q == 2'h3) begin
          next_ls.st = SBM_L_IDLE;
          if (!ls.auto_job) begin
            next_ls.res.err = ls.err;
            next_ls.done_tgl = ~ls.done_tgl;
          end else if (ls.err || (ls.idx == '0 && ls.res.transfer_byte != EEPROM_HEADER)) begin
            next_ls.romerr_tgl = ~ls.romerr_tgl;
            next_ls.eeprom_load_active = 1'b0;
          end else if (ls.idx == SBM_LOAD_LAST) begin
            next_ls.sub_id[7:0] = ls.res.transfer_byte;
            next_ls.eeprom_load_active = 1'b0;
          end else begin
            if (ls.idx != '0) begin
              next_ls.sub_id[15:8] = ls.res.transfer_byte;
            end
            next_ls.idx = ls.idx + 2'h1;
            next_ls.job.byte_address_field = {6'h00, ls.idx + 2'h1};
            next_ls.seg = SBM_SG_ADDR_W;
            next_ls.st = SBM_L_START;
          end
        end
      end
      default: next_ls.st = SBM_L_IDLE;
    endcase
    // Pin drive for the coming quarter
    next_ls.scl_oe_n = 1'b1;
    next_ls.sda_oe_n = 1'b1;
    case (next_ls.st)
      SBM_L_START: begin
        next_ls.scl_oe_n = !(next_ls.q == 2'h0 || next_ls.q == 2'h3);
        next_ls.sda_oe_n = !next_ls.q[1];
      end
      SBM_L_BITS: begin
        next_ls.scl_oe_n = !(next_ls.q == 2'h0 || next_ls.q == 2'h3);
        next_ls.sda_oe_n = !(next_ls.bcnt < SBM_LAST_BIT && !next_ls.tx[7]);
      end
      SBM_L_STOP: begin
        next_ls.scl_oe_n = !(next_ls.q == 2'h0);
        next_ls.sda_oe_n = next_ls.q[1];
      end
      default: begin
        next_ls.scl_oe_n = 1'b1;
      end
    endcase
  end

  // Link engine registers
  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ls <= LINK_RST;
    end else begin
      ls <= next_ls;
    end
  end

  assign pins_out = '{serial_clock_pin_o: 1'b0, serial_clock_pin_oe_n: ls.scl_oe_n,
                      serial_data_pin_o: 1'b0, serial_data_pin_oe_n: ls.sda_oe_n};

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_busy_on_post;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    wr_target |=> rs.request_in_progress;
  endproperty
  a_busy_on_post: assert property (p_busy_on_post) else $error("busy not set");

  property p_rsvd_zero;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    hit(cfg_req_in.rd, cfg_req_in.addr, SBM_OFS_CONTROL_STATUS) |=> !cfg_rdata_out[6];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_req_err_clear;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    hit(cfg_req_in.wr, cfg_req_in.addr, SBM_OFS_CONTROL_STATUS) &&
      cfg_req_in.wdata[SBM_BIT_REQ_ERR] && !done_evt |=> !rs.req_err;
  endproperty
  a_req_err_clear: assert property (p_req_err_clear) else $error("error not cleared");

  property p_rom_err_set;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    romerr_evt |=> rs.rom_err;
  endproperty
  a_rom_err_set: assert property (p_rom_err_set) else $error("eeprom error lost");

  property p_read_capture;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    done_evt && rs.req.direction_bit |=> rs.transfer_byte == $past(ls.res.transfer_byte);
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read byte lost");

  property p_load_blocks_user;
    @(posedge link_clk_in) disable iff (!arst_n_in)
    ls.eeprom_load_active && ls.st != SBM_L_DETECT |-> ls.auto_job;
  endproperty
  a_load_blocks_user: assert property (p_load_blocks_user) else $error("early request");

  property p_address_byte;
    @(posedge link_clk_in) disable iff (!arst_n_in)
    $rose(ls.st == SBM_L_BITS) && ls.seg != SBM_SG_INDEX |->
      ls.tx[7:1] == ls.job.target_address_field && ls.tx[0] == (ls.seg == SBM_SG_ADDR_R);
  endproperty
  a_address_byte: assert property (p_address_byte) else $error("bad address byte");

  property p_short_no_index;
    @(posedge link_clk_in) disable iff (!arst_n_in)
    !ls.auto_job && ls.job.short_protocol_select |-> ls.seg != SBM_SG_INDEX;
  endproperty
  a_short_no_index: assert property (p_short_no_index) else $error("index sent");

  property p_quarter_rate;
    @(posedge link_clk_in) disable iff (!arst_n_in)
    ls.fast_s2 && tick |=> ls.qcnt == QTR_FAST;
  endproperty
  a_quarter_rate: assert property (p_quarter_rate) else $error("wrong clock rate");

  property p_start_cond;
    @(posedge link_clk_in) disable iff (!arst_n_in)
    ls.st == SBM_L_START && ls.q == 2'h2 |-> !ls.sda_oe_n && ls.scl_oe_n;
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("bad start");

  c_write: cover property (@(posedge link_clk_in) ls.seg == SBM_SG_WDATA && ls.st == SBM_L_STOP);
  c_read: cover property (@(posedge link_clk_in) ls.seg == SBM_SG_RDATA && ls.st == SBM_L_STOP);
  c_short: cover property (@(posedge ref_clk_in) done_evt && rs.req.short_protocol_select);
  c_error: cover property (@(posedge ref_clk_in) done_evt && ls.res.err);

endmodule : sbm_serial_bus_byte_master

`default_nettype wire

/* File: sim/sbm_two_wire_target.sv */
// Behavioural two-wire target with a byte memory, far side of the byte master
`default_nettype none
module sbm_two_wire_target #(
  parameter logic [6:0] OWN_ADDR = 7'h3c
) (
  // Open-drain bus levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Data line pull-down, low drives the line
  output logic sda_oe_n_out
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] idx;
  logic rd;
  int n = -1;
  int ph = 0;
  initial sda_oe_n_out = 1'b1;
  // Start or repeated start restarts the frame, keeping the byte address
  always @(negedge sda_in) if (scl_in) begin
    n = 0;
    ph = 0;
    rd = 1'b0;
  end
  // Stop sends the target back to idle
  always @(posedge sda_in) if (scl_in) n = -1;
  // One bit per high phase, most significant first
  always @(posedge scl_in) if (n >= 0 && n < 8) begin
    sh = {sh[6:0], sda_in};
    n++;
  end
  // Acknowledge, store or shift out read data while the clock is low
  always @(negedge scl_in) begin
    sda_oe_n_out = 1'b1;
    if (n == 8) begin
      n = 9;
      if (ph == 0 && sh[7:1] != OWN_ADDR) n = -1;
      else if (ph == 0) rd = sh[0];
      else if (ph == 1) idx = sh;
      else mem[idx] = sh;
      sda_oe_n_out = (n != 9);
    end else if (n == 9) begin
      ph++;
      n = rd ? 20 : 0;
      sh = mem[idx];
    end
    if (n >= 20 && n < 28) begin
      sda_oe_n_out = sh[7];
      sh = sh << 1;
      n++;
    end
  end
endmodule : sbm_two_wire_target
`default_nettype wire

/* File: sim/sbm_serial_bus_byte_master_tb.sv */
// Self-checking bench for the serial-bus byte master and its target model
`default_nettype none
module sbm_serial_bus_byte_master_tb import sbm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  sbm_cfg_req_s cfg_req_in = '0;
  logic [7:0] cfg_rdata_out;
  sbm_pins_s pins_out;
  logic scl, sda, tgt_oe_n, present, load_active;
  logic [15:0] sub_id;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  time t_up = 0;
  time hi_ns = 0;
  logic [7:0] v;
  // Open-drain wires with pull-ups
  assign scl = pins_out.serial_clock_pin_oe_n ? 1'b1 : pins_out.serial_clock_pin_o;
  assign sda = (pins_out.serial_data_pin_oe_n ? 1'b1 : pins_out.serial_data_pin_o) & tgt_oe_n;
  always #5 ref_clk_in = ~ref_clk_in;
  always #24 link_clk_in = ~link_clk_in;
  // Serial clock high time
  always @(posedge scl) t_up = $time;
  always @(negedge scl) hi_ns = $time - t_up;
  sbm_serial_bus_byte_master sbm_serial_bus_byte_master_inst (
    .ref_clk_in(ref_clk_in), .link_clk_in(link_clk_in), .arst_n_in(arst_n_in),
    .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out),
    .serial_clock_pin_in(scl), .serial_data_pin_in(sda), .pins_out(pins_out),
    .bus_present_flag_out(present), .eeprom_load_active_out(load_active),
    .subsystem_id_out(sub_id)
  );
  sbm_two_wire_target #(.OWN_ADDR(7'h3c)) sbm_two_wire_target_inst (
    .scl_in(scl), .sda_in(sda), .sda_oe_n_out(tgt_oe_n)
  );
  task automatic print_verdict;
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1 cfg_req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_in);
    #1 cfg_req_in = '0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    #1 cfg_req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_in);
    #1 cfg_req_in = '0;
    d = cfg_rdata_out;
  endtask : rd_reg
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    check(d, exp);
  endtask : chk_reg
  // Poll busy until it drops
  task automatic wait_idle;
    do rd_reg(SBM_OFS_CONTROL_STATUS, v); while (v[SBM_BIT_BUSY] !== 1'b0);
  endtask : wait_idle
  // Post a request and poll busy until it drops
  task automatic xfer(input logic [7:0] d, input logic [7:0] i, input logic [7:0] t);
    wr_reg(SBM_OFS_TRANSFER_BYTE, d);
    wr_reg(SBM_OFS_BYTE_ADDRESS, i);
    wr_reg(SBM_OFS_TARGET_ADDRESS, t);
    wait_idle();
  endtask : xfer
  // Hang guard
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk_in);
    #1 arst_n_in = 1'b1;
    check({7'h0, load_active}, 8'h01);
    chk_reg(SBM_OFS_TARGET_ADDRESS, 8'h00);
    chk_reg(8'hb4, 8'h00);
    wr_reg(SBM_OFS_TRANSFER_BYTE, 8'hc3);
    wr_reg(SBM_OFS_BYTE_ADDRESS, 8'h5a);
    wr_reg(SBM_OFS_TARGET_ADDRESS, 8'h78);
    chk_reg(SBM_OFS_CONTROL_STATUS, 8'h30);
    wait (load_active === 1'b0);
    check({7'h0, hi_ns > 4000 && hi_ns < 6000}, 8'h01);
    check({7'h0, present}, 8'h01);
    chk_reg(SBM_OFS_CONTROL_STATUS, 8'h29);
    check(sub_id[15:8] | sub_id[7:0], 8'h00);
    wr_reg(SBM_OFS_CONTROL_STATUS, 8'h05);
    chk_reg(SBM_OFS_CONTROL_STATUS, 8'h2c);
    wr_reg(SBM_OFS_TARGET_ADDRESS, 8'h44);
    wait_idle();
    chk_reg(SBM_OFS_CONTROL_STATUS, 8'h0c);
    chk_reg(SBM_OFS_TARGET_ADDRESS, 8'h44);
    check(sbm_two_wire_target_inst.mem[8'h5a], 8'hc3);
    check({7'h0, hi_ns < 1000}, 8'h01);
    xfer(8'h00, 8'h5a, 8'h79);
    chk_reg(SBM_OFS_TRANSFER_BYTE, 8'hc3);
    chk_reg(SBM_OFS_TARGET_ADDRESS, 8'h79);
    wr_reg(SBM_OFS_CONTROL_STATUS, 8'hc4);
    chk_reg(SBM_OFS_CONTROL_STATUS, 8'h8c);
    xfer(8'h5a, 8'h11, 8'h78);
    xfer(8'h00, 8'h11, 8'h79);
    chk_reg(SBM_OFS_TRANSFER_BYTE, 8'hc3);
    wr_reg(SBM_OFS_CONTROL_STATUS, 8'h04);
    xfer(8'h00, 8'h00, 8'h44);
    chk_reg(SBM_OFS_CONTROL_STATUS, 8'h0e);
    wr_reg(SBM_OFS_CONTROL_STATUS, 8'h06);
    chk_reg(SBM_OFS_CONTROL_STATUS, 8'h0c);
    print_verdict();
  end
endmodule : sbm_serial_bus_byte_master_tb
`default_nettype wire
